// ### hdl/tefl_top.v
// timer event flag block: 16-bit counter, wrap and channel flags,
// interrupt request; assumes one AHB-Lite master and synchronous pins
//
// Functional notes
// R1: free up-count runs zero to all ones, wraps
// R2: free mode sets wrap flag at ones-to-zero
// R3: nonzero modulus sets wrap flag at modulus-to-zero
// R4: up/down sets wrap flag reversing at modulus
// R5: capture flag on selected edge of input
// R6: compare flag on every counter match
// R7: edge PWM flag on counter match
// R8: center PWM flag on both matches
// R9: clear by read-while-set then write zero
// R10: level interrupt while enabled flag is one
// R11: up/down counts up to modulus, down to zero
// R12: reset clears flags, enables, counter
`timescale 1ns/1ns
`include "tefl_defs.vh"
module tefl_top #(
    parameter NCH = 2, // channel count, at most 28
    parameter W = 16 // counter width
) (
    input wire CLK,
    input wire RST_N,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output reg [31:0] HRDATA,
    output reg HREADYOUT,
    output reg HRESP,
    input wire [NCH-1:0] CH_IN,
    output reg IRQ
);
    localparam NF = NCH + 1; // wrap flag plus one per channel

    // ==============================
    // state
    reg [1:0] ctrl_r; // run and center_align_select
    reg [W-1:0] mod_r; // modulus limit, zero means none
    reg [W-1:0] cnt_r; // counter
    reg [W-1:0] cnt_nxt;
    reg dir_up_r; // up/down direction, high while counting up
    reg dir_up_nxt;
    reg wrap_evt; // counter wrap this cycle
    reg [NF-1:0] flag_r; // counter_wrap_flag and channel_event_flag bits
    reg [NF-1:0] flag_nxt;
    reg [NF-1:0] arm_r; // flag was read while set
    reg [NF-1:0] arm_nxt;
    reg [NF-1:0] ien_r; // wrap_irq_enable and channel_irq_enable bits
    reg [NF-1:0] ien_nxt;
    reg [3:0] ch_cfg_r [0:NCH-1]; // mode and edge_level_select
    reg [W-1:0] ch_val_r [0:NCH-1]; // compare values
    reg dp_wr_r; // write data phase pending
    reg [7:0] dp_addr_r; // address of that write
    reg [31:0] rd_mux; // read data chosen in address phase
    wire [NCH-1:0] ch_evt; // channel event pulses
    wire [31:0] ch_rd [0:NCH-1]; // per-channel read contributions
    wire run = ctrl_r[`TEFL_CTRL_RUN];
    wire center = ctrl_r[`TEFL_CTRL_CAS];
    // free running when no limit is set; up/down needs a nonzero limit
    wire no_limit = (mod_r == `TEFL_CNT_ZERO);
    wire [W-1:0] limit = no_limit ? `TEFL_CNT_ONES : mod_r;
    wire ap_take = HSEL & HREADY & HTRANS[`TEFL_HTRANS_ACT]; // address phase
    wire ap_rd = ap_take & ~HWRITE;
    wire [7:0] ap_addr = HADDR[7:0];
    wire rd_stat = ap_rd & (ap_addr == `TEFL_OFF_STAT);
    wire wr_ctrl = dp_wr_r & (dp_addr_r == `TEFL_OFF_CTRL);
    wire wr_mod = dp_wr_r & (dp_addr_r == `TEFL_OFF_MOD);
    wire wr_stat = dp_wr_r & (dp_addr_r == `TEFL_OFF_STAT);
    wire wr_ien = dp_wr_r & (dp_addr_r == `TEFL_OFF_IEN);
    wire [NF-1:0] evt = {ch_evt, wrap_evt}; // all flag-setting events
    integer k;

    // ==============================
    // counter step
    always @* begin
        cnt_nxt = cnt_r;
        dir_up_nxt = dir_up_r;
        wrap_evt = 1'b0;
        if (!run) begin
            cnt_nxt = cnt_r; // stopped, hold value
        end else if (center && !no_limit) begin
            if (dir_up_r) begin
                // >= also recovers if the limit is lowered below the count
                if (cnt_r >= mod_r) begin
                    dir_up_nxt = 1'b0; // see R11
                    cnt_nxt = cnt_r - `TEFL_CNT_ONE; // see R11
                    wrap_evt = 1'b1; // see R4
                end else begin
                    cnt_nxt = cnt_r + `TEFL_CNT_ONE; // see R11
                end
            end else if (cnt_r == `TEFL_CNT_ZERO) begin
                dir_up_nxt = 1'b1; // see R11
                cnt_nxt = cnt_r + `TEFL_CNT_ONE; // see R11
            end else begin
                cnt_nxt = cnt_r - `TEFL_CNT_ONE; // see R11
            end
        end else begin
            dir_up_nxt = 1'b1;
            // the ones check catches a limit set below the running count
            if ((cnt_r == limit) || (cnt_r == `TEFL_CNT_ONES)) begin
                cnt_nxt = `TEFL_CNT_ZERO; // see R1 see R3
                wrap_evt = 1'b1; // see R2 see R3
            end else begin
                cnt_nxt = cnt_r + `TEFL_CNT_ONE; // see R1
            end
        end
    end

    // ==============================
    // flags, two-step clear and enables
    always @* begin
        arm_nxt = arm_r;
        flag_nxt = flag_r;
        ien_nxt = ien_r;
        if (wr_stat) begin
            // written zero on an armed bit clears it; ones leave it alone
            flag_nxt = flag_r & ~(arm_r & ~HWDATA[NF-1:0]); // see R9
            arm_nxt = {NF{1'b0}}; // see R9
        end
        if (rd_stat) begin
            arm_nxt = arm_nxt | flag_r; // see R9
        end
        // a new event sets the flag and restarts the sequence
        flag_nxt = flag_nxt | evt; // see R9
        arm_nxt = arm_nxt & ~evt; // see R9
        if (wr_ien) begin
            ien_nxt = HWDATA[NF-1:0];
        end
    end

    // ==============================
    // channels
    genvar i;
    generate
        for (i = 0; i < NCH; i = i + 1) begin : g_ch
            // full-width sum first, then the low byte kept on purpose
            localparam [31:0] CFG_W = `TEFL_OFF_CH0 + i * `TEFL_CH_STRIDE;
            localparam [7:0] CFG_A = CFG_W[7:0];
            localparam [7:0] VAL_A = CFG_A + `TEFL_CH_VAL_OFS;
            // config and value registers of this channel
            always @(posedge CLK) begin
                if (!RST_N) begin
                    ch_cfg_r[i] <= `TEFL_CFG_RST;
                    ch_val_r[i] <= `TEFL_CNT_ZERO;
                end else if (dp_wr_r) begin
                    if (dp_addr_r == CFG_A) begin
                        ch_cfg_r[i] <= HWDATA[3:0];
                    end
                    if (dp_addr_r == VAL_A) begin
                        ch_val_r[i] <= HWDATA[W-1:0];
                    end
                end
            end
            // read contribution, zero when not addressed
            assign ch_rd[i] = (ap_addr == CFG_A) ? {28'h0000000, ch_cfg_r[i]} :
                (ap_addr == VAL_A) ? {{(32-W){1'b0}}, ch_val_r[i]} :
                `TEFL_WORD_ZERO;
            tefl_chan #(
                .W(W)
            ) u_chan (
                .clk(CLK),
                .rst_n(RST_N),
                .run(run),
                .cnt(cnt_r),
                .val(ch_val_r[i]),
                .mode(ch_cfg_r[i][`TEFL_CFG_MODE]),
                .edge_sel(ch_cfg_r[i][`TEFL_CFG_EDGE]),
                .pin_in(CH_IN[i]),
                .event_r(ch_evt[i])
            );
        end
    endgenerate

    // ==============================
    // read mux, evaluated in the address phase
    always @* begin
        rd_mux = `TEFL_WORD_ZERO; // unmapped reads return zero
        case (ap_addr)
            `TEFL_OFF_CTRL: rd_mux = {{30{1'b0}}, ctrl_r};
            `TEFL_OFF_MOD: rd_mux = {{(32-W){1'b0}}, mod_r};
            `TEFL_OFF_CNT: begin
                rd_mux[W-1:0] = cnt_r;
                rd_mux[`TEFL_CNT_DIR] = dir_up_r;
            end
            `TEFL_OFF_STAT: rd_mux[NF-1:0] = flag_r;
            `TEFL_OFF_IEN: rd_mux[NF-1:0] = ien_r;
            default: begin
                for (k = 0; k < NCH; k = k + 1) begin
                    rd_mux = rd_mux | ch_rd[k];
                end
            end
        endcase
    end

    // ==============================
    // bus slave: zero wait states, always OKAY
    always @(posedge CLK) begin
        if (!RST_N) begin
            dp_wr_r <= 1'b0;
            dp_addr_r <= 8'h00;
            HRDATA <= `TEFL_WORD_ZERO;
            HREADYOUT <= 1'b0;
            HRESP <= 1'b0;
        end else begin
            dp_wr_r <= ap_take & HWRITE;
            dp_addr_r <= ap_addr;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            if (ap_rd) begin
                HRDATA <= rd_mux;
            end
        end
    end

    // ==============================
    // counter, control and flag registers
    always @(posedge CLK) begin
        if (!RST_N) begin
            ctrl_r <= `TEFL_CTRL_RST; // see R12
            mod_r <= `TEFL_CNT_ZERO;
            cnt_r <= `TEFL_CNT_ZERO; // see R12
            dir_up_r <= 1'b1;
            flag_r <= {NF{1'b0}}; // see R12
            arm_r <= {NF{1'b0}};
            ien_r <= {NF{1'b0}}; // see R12
            IRQ <= 1'b0; // see R12
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= HWDATA[1:0];
            end
            if (wr_mod) begin
                mod_r <= HWDATA[W-1:0];
            end
            cnt_r <= cnt_nxt;
            dir_up_r <= dir_up_nxt;
            flag_r <= flag_nxt;
            arm_r <= arm_nxt;
            ien_r <= ien_nxt;
            // built from next values so it tracks the flags cycle for cycle
            IRQ <= |(flag_nxt & ien_nxt); // see R10
        end
    end
endmodule // tefl_top

// ### hdl/tefl_defs.vh
// constants of the timer event flag block: register map, field positions,
// reset values and encodings; assumes byte addresses decoded on haddr[7:0]
`ifndef TEFL_DEFS_VH
`define TEFL_DEFS_VH
// ==============================
// register byte offsets
`define TEFL_OFF_CTRL 8'h00
`define TEFL_OFF_MOD 8'h04
`define TEFL_OFF_CNT 8'h08
`define TEFL_OFF_STAT 8'h0c
`define TEFL_OFF_IEN 8'h10
`define TEFL_OFF_CH0 8'h20
`define TEFL_CH_STRIDE 8'h08
`define TEFL_CH_VAL_OFS 8'h04
// ==============================
// field positions
`define TEFL_CTRL_RUN 0
`define TEFL_CTRL_CAS 1
`define TEFL_CNT_DIR 16
`define TEFL_WRAP_BIT 0
`define TEFL_CFG_MODE 1:0
`define TEFL_CFG_EDGE 3:2
`define TEFL_HTRANS_ACT 1
// ==============================
// reset values and encodings
`define TEFL_CTRL_RST 2'h0
`define TEFL_CFG_RST 4'h0
`define TEFL_CNT_ZERO 16'h0000
`define TEFL_CNT_ONES 16'hffff
`define TEFL_CNT_ONE 16'h0001
`define TEFL_MODE_CAP 2'h0
`define TEFL_MODE_CMP 2'h1
`define TEFL_MODE_PWM 2'h2
`define TEFL_EDGE_NONE 2'h0
`define TEFL_EDGE_RISE 2'h1
`define TEFL_EDGE_FALL 2'h2
`define TEFL_EDGE_BOTH 2'h3
`define TEFL_WORD_ZERO 32'h0000_0000
`endif

// ### hdl/tefl_chan.v
// one timer channel: turns a capture edge or a counter match into an
// event pulse; assumes the pin input is already synchronous to clk
`timescale 1ns/1ns
`include "tefl_defs.vh"
module tefl_chan #(
    parameter W = 16
) (
    input wire clk,
    input wire rst_n,
    input wire run,
    input wire [W-1:0] cnt,
    input wire [W-1:0] val,
    input wire [1:0] mode,
    input wire [1:0] edge_sel,
    input wire pin_in,
    output reg event_r
);
    reg pin_prev_r; // pin level one cycle ago
    reg event_nxt; // event of this cycle
    wire rise = pin_in & ~pin_prev_r;
    wire fall = ~pin_in & pin_prev_r;
    wire match = run & (cnt == val); // one hit per counter value held

    // ==============================
    // event decode
    always @* begin
        event_nxt = 1'b0;
        case (mode)
            `TEFL_MODE_CAP: begin
                case (edge_sel)
                    `TEFL_EDGE_RISE: event_nxt = rise; // see R5
                    `TEFL_EDGE_FALL: event_nxt = fall; // see R5
                    `TEFL_EDGE_BOTH: event_nxt = rise | fall; // see R5
                    default: event_nxt = 1'b0; // capture off
                endcase
            end
            `TEFL_MODE_CMP: event_nxt = match; // see R6
            // up/down count passes the value twice a period, so two hits
            `TEFL_MODE_PWM: event_nxt = match; // see R7 see R8
            default: event_nxt = 1'b0; // unused mode code is channel off
        endcase
    end

    // ==============================
    // edge history and event pulse
    always @(posedge clk) begin
        if (!rst_n) begin
            pin_prev_r <= 1'b0;
            event_r <= 1'b0;
        end else begin
            pin_prev_r <= pin_in;
            event_r <= event_nxt;
        end
    end
endmodule // tefl_chan

// ### tb/tefl_monitor.sv
// checker of tefl_top: bus answers, reset state, irq against enables
// assumes binding to tefl_top, a single master and a zero-wait slave
`timescale 1ns/1ns
`include "tefl_defs.vh"
module tefl_monitor #(
    parameter NCH = 2
) (
    input wire CLK,
    input wire RST_N,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    input wire [31:0] HRDATA,
    input wire HREADYOUT,
    input wire HRESP,
    input wire IRQ
);
    // ========================================
    // bus phase shadow
    reg wr_r; // write data phase
    reg rd_r; // read data phase
    reg [7:0] adr_r; // address of the phase
    reg [NCH:0] ien_r; // enable shadow
    // writes land at the data-phase edge, like the design
    always @(posedge CLK) begin
        if (!RST_N) begin
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            ien_r <= {(NCH+1){1'b0}};
        end else begin
            if (wr_r && adr_r == `TEFL_OFF_IEN) begin
                ien_r <= HWDATA[NCH:0];
            end
            wr_r <= HSEL && HREADY && HTRANS[1] && HWRITE;
            rd_r <= HSEL && HREADY && HTRANS[1] && !HWRITE;
            adr_r <= HADDR[7:0];
        end
    end
    // ========================================
    // properties
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    okay_resp_a: assert property (HRESP == 1'b0) else $error("error response");
    ready_high_a: assert property ($past(RST_N) |-> HREADYOUT) else $error("wait state");
    reset_quiet_a: assert property (
        disable iff (1'b0) !RST_N |=> !IRQ && HRDATA == 32'h0)
        else $error("outputs active in reset");
    irq_masked_a: assert property (ien_r == 0 |-> !IRQ) else $error("irq while masked");
    // a flag seen set cannot have cleared unless a write ended at that edge
    irq_follows_a: assert property (rd_r && adr_r == `TEFL_OFF_STAT && !$past(wr_r)
        && |(HRDATA[NCH:0] & ien_r) |-> IRQ) else $error("irq low");
    rdata_hold_a: assert property (!rd_r |-> $stable(HRDATA)) else $error("read data moved");
    hole_zero_a: assert property (rd_r && adr_r > 8'h13 && adr_r < 8'h20 |-> HRDATA == 0)
        else $error("hole read nonzero");
    cnt_upper_a: assert property (rd_r && adr_r == `TEFL_OFF_CNT |-> HRDATA[31:17] == 0)
        else $error("count upper bits");
    stat_upper_a: assert property (rd_r && adr_r == `TEFL_OFF_STAT |-> HRDATA[31:NCH+1] == 0)
        else $error("status upper bits");
endmodule // tefl_monitor

bind tefl_top tefl_monitor #(.NCH(NCH)) i_tefl_monitor (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ));

// ### tb/test_tefl_top.sv
// self-checking bench of tefl_top driven over AHB-Lite
// assumes two channels; no pin of the block is left undriven
`timescale 1ns/1ns
`include "tefl_defs.vh"
module test_tefl_top;
    reg CLK = 1'b0;
    reg RST_N = 1'b0;
    reg HSEL = 1'b0;
    reg [31:0] HADDR = 32'h0;
    reg [1:0] HTRANS = 2'h0;
    reg HWRITE = 1'b0;
    reg [31:0] HWDATA = 32'h0;
    reg [1:0] CH_IN = 2'h0;
    wire [31:0] HRDATA;
    wire HREADYOUT;
    wire HRESP;
    wire IRQ;
    integer n_errors = 0;
    integer n_compared = 0;
    integer i, k, hits, wraps;
    reg [31:0] d, e; // read results
    localparam [7:0] CT = `TEFL_OFF_CTRL;
    localparam [7:0] MD = `TEFL_OFF_MOD;
    localparam [7:0] CN = `TEFL_OFF_CNT;
    localparam [7:0] ST = `TEFL_OFF_STAT;
    localparam [7:0] IE = `TEFL_OFF_IEN;
    // ========================================
    // device and clock
    tefl_top #(.NCH(2), .W(16)) i_tefl_top (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .CH_IN(CH_IN), .IRQ(IRQ));
    initial begin
        forever #5 CLK = ~CLK;
    end
    // ========================================
    // shared tasks
    task chk(input string nm, input [31:0] ex, input [31:0] got);
        begin
            n_compared = n_compared + 1;
            if (got !== ex) begin
                n_errors = n_errors + 1;
                $display("FAIL %s expected %h seen %h", nm, ex, got);
            end
        end
    endtask
    // one single transfer; waits on ready in both phases
    task bus(input w, input [7:0] a, input [31:0] wd, output [31:0] rd);
        begin
            HSEL <= 1'b1;
            HTRANS <= 2'h2;
            HWRITE <= w;
            HADDR <= {24'h0, a};
            do @(posedge CLK); while (HREADYOUT !== 1'b1);
            HTRANS <= 2'h0;
            HSEL <= 1'b0;
            HWDATA <= wd;
            do @(posedge CLK); while (HREADYOUT !== 1'b1);
            rd = HRDATA;
        end
    endtask
    task rst;
        begin
            RST_N <= 1'b0;
            CH_IN <= 2'h0;
            repeat (5) @(posedge CLK);
            RST_N <= 1'b1;
            repeat (2) @(posedge CLK);
        end
    endtask
    // ========================================
    // scenarios
    task t_reset;
        begin
            rst;
            chk("irq", 0, IRQ);
            bus(0, ST, 0, d);
            chk("status", 0, d);
            bus(0, IE, 0, d);
            chk("enable", 0, d);
            bus(1, CN, 32'h1234, d);
            bus(1, 8'h14, 32'hffff_ffff, d);
            bus(0, 8'h14, 0, d);
            chk("hole", 0, d);
            bus(0, CN, 0, d);
            // count reads zero, direction bit 16 reads one (counting up)
            chk("count", 32'h0001_0000, d);
        end
    endtask
    // every edge code, both pin directions; channel 1 stays off
    task t_cap;
        begin
            rst;
            for (i = 0; i < 4; i = i + 1) begin
                bus(1, 8'h20, i << 2, d);
                CH_IN <= 2'h3;
                repeat (3) @(posedge CLK);
                bus(0, ST, 0, d);
                chk("rise", i[0], d[1]);
                chk("none", 0, d[2]);
                bus(1, ST, 0, e);
                CH_IN <= 2'h0;
                repeat (3) @(posedge CLK);
                bus(0, ST, 0, d);
                chk("fall", i[1], d[1]);
                bus(1, ST, 0, e);
            end
            // mode code 3 switches the channel off even with both edges chosen
            bus(1, 8'h20, 32'hf, d);
            CH_IN <= 2'h1;
            repeat (3) @(posedge CLK);
            CH_IN <= 2'h0;
            repeat (3) @(posedge CLK);
            bus(0, ST, 0, d);
            chk("off", 0, d[1]);
        end
    endtask
    task t_updown;
        begin
            rst;
            bus(1, MD, 32'h40, d);
            bus(1, CT, 3, d);
            k = 0;
            e = 32'h1_0000;
            // poll until the direction turns; near the top a flag may race the read
            while (e[16] && k < 200) begin
                bus(0, ST, 0, d);
                chk("early", 0, d[0] & (e[15:0] < 16'h3c));
                bus(0, CN, 0, e);
                chk("limit", 1, e[15:0] <= 16'h40);
                k = k + 1;
            end
            chk("turned", 1, e[15:0] > 16'h3b);
            bus(1, IE, 1, d);
            @(posedge CLK);
            chk("irq_on", 1, IRQ);
            bus(1, ST, 1, d);
            bus(1, ST, 0, d);
            @(posedge CLK);
            chk("unarmed", 1, IRQ);
            bus(1, IE, 0, d);
            @(posedge CLK);
            chk("masked", 0, IRQ);
            bus(1, IE, 1, d);
            bus(0, ST, 0, d);
            bus(1, ST, 0, e);
            @(posedge CLK);
            chk("irq_off", 0, IRQ);
            bus(0, ST, 0, d);
            chk("cleared", 0, d);
        end
    endtask
    // counts channel hits between two wraps, clearing after each poll
    task t_pwm(input [1:0] m, input c, input [31:0] ex);
        begin
            rst;
            bus(1, 8'h2c, 32'h10, d);
            bus(1, 8'h28, m, d);
            bus(1, MD, 32'h40, d);
            bus(1, CT, {c, 1'b1}, d);
            hits = 0;
            wraps = 0;
            k = 0;
            while (wraps < 2 && k < 400) begin
                bus(0, ST, 0, d);
                bus(1, ST, 0, e);
                wraps = wraps + d[0];
                if (wraps == 1) hits = hits + d[2];
                k = k + 1;
            end
            chk("wraps", 2, wraps);
            chk("hits", ex, hits);
        end
    endtask
    task t_free;
        begin
            rst;
            bus(1, CT, 1, d);
            bus(0, CN, 0, d);
            bus(0, CN, 0, e);
            chk("step", d[15:0] + 2, e[15:0]);
            bus(0, ST, 0, d);
            k = 0;
            while (d[0] !== 1'b1 && k < 40000) begin
                bus(0, ST, 0, d);
                k = k + 1;
            end
            bus(0, CN, 0, e);
            chk("wrapped", 1, k > 30000 && e[15:0] < 16'h10);
        end
    endtask
    // ========================================
    // sequence, watchdog and verdict
    initial begin
        t_reset;
        t_cap;
        t_updown;
        t_pwm(2'h1, 1'b0, 1);
        t_pwm(2'h2, 1'b0, 1);
        t_pwm(2'h2, 1'b1, 2);
        t_free;
        print_verdict;
    end
    initial begin
        repeat (95000) @(posedge CLK);
        n_errors = n_errors + 1;
        print_verdict;
    end
    task print_verdict;
        begin
            $display("compared %0d errors %0d", n_compared, n_errors);
            if (n_errors == 0 && n_compared > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
endmodule // test_tefl_top
